// [hdl/isf_bus_mon.sv]
// bus monitor: start/stop detection and bus-busy state on sampled scl/sda
`timescale 1ns/1ns
module isf_bus_mon (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise_o,
  output logic      start_o,
  output logic      stop_o,
  output logic      bus_busy_o
);
  logic scl_q;
  logic sda_q;
  logic busy_q;
  // bus-busy lives outside module reset so it holds while stopped
  logic seen_start;
  logic seen_stop;
  assign seen_start = run_i && scl_i && scl_q && sda_q && !sda_i;
  assign seen_stop  = run_i && scl_i && scl_q && !sda_q && sda_i;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (seen_start) begin
        busy_q <= 1'b1;
      end else if (seen_stop) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign scl_rise_o = scl_i && !scl_q;
  assign start_o    = seen_start;
  assign stop_o     = seen_stop;
  assign bus_busy_o = busy_q;
endmodule // isf_bus_mon

// [hdl/isf_flags.sv]
// status-flag logic of an i2c controller with an axi4-lite register slave
//
// Behaviour
// - receive-ready sets when a byte moves from the rx shift register into the rx data buffer.
// - in master mode only, regs-access-ready sets when the loaded settings are all used.
// - regs-access-ready clears when the settings start to be used, on write-1, or reset.
// - non-repeat with stop request low sets regs-access-ready at count 0, else a stop is issued.
// - while transmitting, a not-acknowledge sampled from the receiver sets the nack flag.
// - nack clears on an ack, write-1, a processor read of source code nack, or reset.
// - during a general call transfer the nack flag reads 1 regardless of acks.
// - as master-transmitter, losing arbitration sets the arbitration-lost flag.
// - a transfer start attempted while bus busy reads 1 also sets arbitration-lost.
// - arbitration-lost clears on write-1, a processor read of source code al, or reset.
// - when arbitration-lost becomes 1 the master and stop-request bits clear.
// - while the module is stopped, start/stop is not seen and bus-busy keeps its value.
// - a processor read of source codes 001 or 010 clears the matching status flag.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module isf_flags
  import isf_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // axi4-lite slave
  input  wire logic [isf_pkg::ISF_AW-1:0] s_awaddr_i,
  input  wire logic                  s_awvalid_i,
  output logic                       s_awready_o,
  input  wire logic [isf_pkg::ISF_DW-1:0] s_wdata_i,
  input  wire logic [3:0]            s_wstrb_i,
  input  wire logic                  s_wvalid_i,
  output logic                       s_wready_o,
  output logic [1:0]                 s_bresp_o,
  output logic                       s_bvalid_o,
  input  wire logic                  s_bready_i,
  input  wire logic [isf_pkg::ISF_AW-1:0] s_araddr_i,
  input  wire logic                  s_arvalid_i,
  output logic                       s_arready_o,
  output logic [isf_pkg::ISF_DW-1:0] s_rdata_o,
  output logic [1:0]                 s_rresp_o,
  output logic                       s_rvalid_o,
  input  wire logic                  s_rready_i,
  input  wire logic                  s_debug_i,
  // i2c pins (sampled, asynchronous)
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  // events from the rest of the controller (same clock)
  input  wire logic                  rx_byte_moved_i,
  input  wire logic [7:0]            rx_byte_i,
  input  wire logic                  settings_used_i,
  input  wire logic                  settings_done_i,
  input  wire logic                  cnt_dec_i,
  input  wire logic [CNT_W-1:0]      cnt_load_i,
  input  wire logic                  cnt_load_en_i,
  input  wire logic                  transmitting_i,
  input  wire logic                  ack_sample_i,
  input  wire logic                  general_call_i,
  input  wire logic                  arb_lost_i,
  // outputs
  output logic                       stop_gen_o,
  output logic                       master_o,
  output logic                       stop_req_o,
  output logic [2:0]                 int_code_o,
  output logic                       irq_o
);
  logic [ISF_NFLAGS-1:0] flag_q, flag_d;
  logic [ISF_NFLAGS-1:0] irq_en_q;
  logic [ISF_MD_W-1:0]   mode_q, mode_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [7:0]            rxbuf_q;
  logic                  scl_s, sda_s;
  logic                  scl_rise, bus_start, bus_stop, bus_busy;

  isf_sync #(.W(2)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     ({scl_s, sda_s})
  );

  isf_bus_mon u_mon (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (mode_q[ISF_MD_RUN]),
    .scl_i      (scl_s),
    .sda_i      (sda_s),
    .scl_rise_o (scl_rise),
    .start_o    (bus_start),
    .stop_o     (bus_stop),
    .bus_busy_o (bus_busy)
  );

  // module reset: run bit low holds the flags and counter cleared
  logic run;
  assign run = mode_q[ISF_MD_RUN];

  // ---- axi4-lite write path: address and data taken in either order
  logic                  aw_have_q, w_have_q, bvalid_q;
  logic [ISF_AW-1:0]     awaddr_q;
  logic [ISF_DW-1:0]     wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bresp_err_q;
  logic                  wr_fire;
  assign s_awready_o = !aw_have_q && !bvalid_q;
  assign s_wready_o  = !w_have_q && !bvalid_q;
  assign wr_fire     = aw_have_q && w_have_q && !bvalid_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_wdata_i;
        wstrb_q  <= s_wstrb_i;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
      end else if (bvalid_q && s_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  logic wa_status, wa_mode, wa_en, wa_cmd, wa_ok, wlane0;
  assign wlane0    = wstrb_q[0];
  assign wa_status = wr_fire && wlane0 && (awaddr_q == ISF_ADDR_STATUS);
  assign wa_mode   = wr_fire && wlane0 && (awaddr_q == ISF_ADDR_MODE);
  assign wa_en     = wr_fire && wlane0 && (awaddr_q == ISF_ADDR_IRQ_EN);
  assign wa_cmd    = wr_fire && wlane0 && (awaddr_q == ISF_ADDR_CMD);
  assign wa_ok     = (awaddr_q == ISF_ADDR_STATUS) || (awaddr_q == ISF_ADDR_MODE) ||
                     (awaddr_q == ISF_ADDR_IRQ_EN) || (awaddr_q == ISF_ADDR_CMD) ||
                     (awaddr_q == ISF_ADDR_ISRC) || (awaddr_q == ISF_ADDR_RXDATA);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bresp_err_q <= 1'b0;
    end else if (wr_fire) begin
      bresp_err_q <= !wa_ok;
    end
  end
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o  = bresp_err_q ? ISF_RESP_SLVERR : ISF_RESP_OKAY;

  // ---- interrupt source: highest-priority pending enabled flag
  logic [ISF_NFLAGS-1:0] pend;
  logic [2:0]            code;
  assign pend = flag_q & irq_en_q;
  assign code = pend[ISF_ST_AL]   ? ISF_CODE_AL :
                pend[ISF_ST_NACK] ? ISF_CODE_NACK :
                pend[ISF_ST_REGS_ACCESS_READY_FLAG] ? ISF_CODE_REGS_ACCESS_READY_FLAG :
                pend[ISF_ST_RECEIVE_READY_FLAG] ? ISF_CODE_RECEIVE_READY_FLAG : ISF_CODE_NONE;

  // narrow fields sit in the low bits of the 32-bit word, the rest reads 0
  localparam int STATUS_W = 16;
  localparam int CODE_W   = 3;
  localparam int BYTE_W   = 8;

  // ---- axi4-lite read path, one cycle to rvalid
  logic                  rvalid_q;
  logic [ISF_DW-1:0]     rdata_q;
  logic [1:0]            rresp_q;
  logic                  rd_fire;
  logic                  rd_isrc_cpu, rd_rx_cpu;
  logic [ISF_DW-1:0]     rd_word;
  logic                  rd_ok;
  logic [STATUS_W-1:0]   status_word;
  // general call forces the reported nack to 1 without storing it
  logic                  nack_view;
  assign nack_view   = flag_q[ISF_ST_NACK] || general_call_i;
  assign status_word = {3'h0, bus_busy, 8'h0, flag_q[ISF_ST_RECEIVE_READY_FLAG],
                        flag_q[ISF_ST_REGS_ACCESS_READY_FLAG], nack_view, flag_q[ISF_ST_AL]};
  assign s_arready_o = !rvalid_q;
  assign rd_fire     = s_arvalid_i && s_arready_o;
  assign rd_ok       = (s_araddr_i == ISF_ADDR_STATUS) || (s_araddr_i == ISF_ADDR_MODE) ||
                       (s_araddr_i == ISF_ADDR_ISRC) || (s_araddr_i == ISF_ADDR_RXDATA) ||
                       (s_araddr_i == ISF_ADDR_IRQ_EN) || (s_araddr_i == ISF_ADDR_CMD);
  // debugger reads leave every flag alone
  assign rd_isrc_cpu = rd_fire && !s_debug_i && (s_araddr_i == ISF_ADDR_ISRC);
  assign rd_rx_cpu   = rd_fire && !s_debug_i && (s_araddr_i == ISF_ADDR_RXDATA);
  always_comb begin
    rd_word = '0;
    if (s_araddr_i == ISF_ADDR_STATUS) begin
      rd_word[STATUS_W-1:0] = status_word;
    end else if (s_araddr_i == ISF_ADDR_MODE) begin
      rd_word[ISF_MD_W-1:0] = mode_q;
    end else if (s_araddr_i == ISF_ADDR_ISRC) begin
      rd_word[CODE_W-1:0] = code;
    end else if (s_araddr_i == ISF_ADDR_RXDATA) begin
      rd_word[BYTE_W-1:0] = rxbuf_q;
    end else if (s_araddr_i == ISF_ADDR_IRQ_EN) begin
      rd_word[ISF_NFLAGS-1:0] = irq_en_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= ISF_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? ISF_RESP_OKAY : ISF_RESP_SLVERR;
    end else if (rvalid_q && s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o  = rdata_q;
  assign s_rresp_o  = rresp_q;

  // ---- data counter and start attempt
  logic cnt_zero_hit, start_try, start_busy;
  assign cnt_zero_hit = cnt_dec_i && (cnt_q == CNT_W'(1));
  assign start_try    = wa_cmd && wdata_q[ISF_CMD_START];
  assign start_busy   = start_try && bus_busy;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run) begin
      cnt_q <= '0;
    end else if (cnt_load_en_i) begin
      cnt_q <= cnt_load_i;
    end else if (cnt_dec_i && cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end
  // stop at zero when requested, instead of ready
  assign stop_gen_o = cnt_zero_hit && !mode_q[ISF_MD_RM] && mode_q[ISF_MD_STP];

  // ---- flag set and clear terms
  logic [ISF_NFLAGS-1:0] set_v, clr_v;
  logic                  ack_seen, nack_seen, master_tx;
  assign ack_seen  = transmitting_i && scl_rise && !sda_s;
  assign nack_seen = transmitting_i && scl_rise && sda_s;
  assign master_tx = mode_q[ISF_MD_MST] && transmitting_i;
  assign set_v[ISF_ST_RECEIVE_READY_FLAG] = rx_byte_moved_i;
  assign set_v[ISF_ST_REGS_ACCESS_READY_FLAG] = mode_q[ISF_MD_MST] && (settings_done_i ||
                              (cnt_zero_hit && !mode_q[ISF_MD_RM] && !mode_q[ISF_MD_STP]));
  assign set_v[ISF_ST_NACK] = nack_seen && ack_sample_i;
  assign set_v[ISF_ST_AL]   = (master_tx && arb_lost_i) || start_busy;
  assign clr_v[ISF_ST_RECEIVE_READY_FLAG] = (wa_status && wdata_q[ISF_ST_RECEIVE_READY_FLAG]) || rd_rx_cpu;
  assign clr_v[ISF_ST_REGS_ACCESS_READY_FLAG] = settings_used_i || (wa_status && wdata_q[ISF_ST_REGS_ACCESS_READY_FLAG]);
  assign clr_v[ISF_ST_NACK] = (ack_seen && ack_sample_i) ||
                              (wa_status && wdata_q[ISF_ST_NACK]) ||
                              (rd_isrc_cpu && code == ISF_CODE_NACK);
  assign clr_v[ISF_ST_AL]   = (wa_status && wdata_q[ISF_ST_AL]) ||
                              (rd_isrc_cpu && code == ISF_CODE_AL);
  // set beats clear so a same-cycle event is kept
  assign flag_d = set_v | (flag_q & ~clr_v);

  // losing arbitration drops master and stop request; every loss does so,
  // so a master bit rewritten while the flag still stands is kept until the next loss
  logic al_event;
  assign al_event = set_v[ISF_ST_AL];
  always_comb begin
    mode_d = mode_q;
    if (wa_mode) begin
      mode_d = wdata_q[ISF_MD_W-1:0];
    end
    if (al_event) begin
      mode_d[ISF_MD_MST] = 1'b0;
      mode_d[ISF_MD_STP] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_q   <= '0;
      irq_en_q <= '0;
    end else begin
      mode_q <= mode_d;
      if (wa_en) begin
        irq_en_q <= wdata_q[ISF_NFLAGS-1:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run) begin
      flag_q  <= '0;
      rxbuf_q <= '0;
    end else begin
      flag_q <= flag_d;
      if (rx_byte_moved_i) begin
        rxbuf_q <= rx_byte_i;
      end
    end
  end

  assign master_o   = mode_q[ISF_MD_MST];
  assign stop_req_o = mode_q[ISF_MD_STP];
  assign int_code_o = code;
  assign irq_o      = |pend;
endmodule // isf_flags

// [hdl/isf_pkg.sv]
// package: register map, field positions and codes of the status-flag block
package isf_pkg;
  // register byte addresses
  localparam logic [7:0] ISF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] ISF_ADDR_MODE   = 8'h04;
  localparam logic [7:0] ISF_ADDR_ISRC   = 8'h08;
  localparam logic [7:0] ISF_ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ISF_ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ISF_ADDR_CMD    = 8'h14;
  // status bit positions
  localparam int ISF_ST_AL   = 0;
  localparam int ISF_ST_NACK = 1;
  localparam int ISF_ST_REGS_ACCESS_READY_FLAG = 2;
  localparam int ISF_ST_RECEIVE_READY_FLAG = 3;
  localparam int ISF_ST_BB   = 12;
  localparam int ISF_NFLAGS  = 4;
  // mode control bit positions
  localparam int ISF_MD_RM   = 0;
  localparam int ISF_MD_STP  = 1;
  localparam int ISF_MD_MST  = 2;
  localparam int ISF_MD_RUN  = 3;
  localparam int ISF_MD_W    = 4;
  // command register bit: start a transfer
  localparam int ISF_CMD_START = 0;
  // interrupt source codes
  localparam logic [2:0] ISF_CODE_NONE = 3'h0;
  localparam logic [2:0] ISF_CODE_AL   = 3'h1;
  localparam logic [2:0] ISF_CODE_NACK = 3'h2;
  localparam logic [2:0] ISF_CODE_REGS_ACCESS_READY_FLAG = 3'h3;
  localparam logic [2:0] ISF_CODE_RECEIVE_READY_FLAG = 3'h4;
  // axi responses
  localparam logic [1:0] ISF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ISF_RESP_SLVERR = 2'h2;
  localparam int ISF_DW = 32;
  localparam int ISF_AW = 8;
endpackage

// [hdl/isf_sync.sv]
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module isf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // isf_sync

// [verification/i2c_status_flag_logic_test.sv]
// testbench: status-flag block driven over its register bus and bus pins
`timescale 1ns/1ns
module i2c_status_flag_logic_test;
  import isf_pkg::*;
  logic        clk_i, rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i;
  logic        s_rready_i, s_debug_i, rx_byte_moved_i, settings_used_i, settings_done_i;
  logic        cnt_dec_i, cnt_load_en_i, transmitting_i, ack_sample_i, general_call_i;
  logic        arb_lost_i, scl_i, sda_i, s_awready_o, s_wready_o, s_bvalid_o, s_arready_o;
  logic        s_rvalid_o, stop_gen_o, master_o, stop_req_o, irq_o, saw_stop;
  logic [7:0]  s_awaddr_i, s_araddr_i, rx_byte_i, cnt_load_i;
  logic [3:0]  s_wstrb_i;
  logic [1:0]  s_bresp_o, s_rresp_o, resp;
  logic [31:0] s_wdata_i, s_rdata_o, rdat;
  logic [2:0]  int_code_o;
  int          num_errors = 0, samples_checked = 0, cycles = 0;
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  isf_flags #(.CNT_W(8)) u_dut (.clk_i, .rst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
    .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
    .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
    .s_debug_i, .scl_i, .sda_i, .rx_byte_moved_i, .rx_byte_i, .settings_used_i,
    .settings_done_i, .cnt_dec_i, .cnt_load_i, .cnt_load_en_i, .transmitting_i, .ack_sample_i,
    .general_call_i, .arb_lost_i, .stop_gen_o, .master_o, .stop_req_o, .int_code_o, .irq_o);
  isf_bus_model u_bus (.scl_o(scl_i), .sda_o(sda_i));
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (stop_gen_o === 1'b1) saw_stop <= 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // requests held until ready is seen high at the taking edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_i);
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i  <= 1'b1;
    s_bready_i  <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_awready_o;
      tw = s_wready_o;
      tb = s_bvalid_o;
      resp = s_bresp_o;
      @(posedge clk_i);
      if (ta) s_awvalid_i <= 1'b0;
      if (tw) s_wvalid_i <= 1'b0;
      if (tb) s_bready_i <= 1'b0;
    end while (tb !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic dbg, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk_i);
    s_araddr_i  <= a;
    s_debug_i   <= dbg;
    s_arvalid_i <= 1'b1;
    s_rready_i  <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_arready_o;
      tr = s_rvalid_o;
      d  = s_rdata_o;
      r  = s_rresp_o;
      @(posedge clk_i);
      if (ta) s_arvalid_i <= 1'b0;
      if (tr) s_rready_i <= 1'b0;
    end while (tr !== 1'b1);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, 1'b0, rdat, resp);
    chk(rdat, e);
  endtask
  initial begin
    {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i, s_debug_i, rst_n_i,
     rx_byte_moved_i, settings_used_i, settings_done_i, cnt_dec_i, cnt_load_en_i,
     transmitting_i, ack_sample_i, general_call_i, arb_lost_i, saw_stop} <= '0;
    {s_awaddr_i, s_araddr_i, rx_byte_i, cnt_load_i, s_wdata_i} <= '0;
    s_wstrb_i <= 4'hf;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc(ISF_ADDR_STATUS, 32'h0);
    rc(ISF_ADDR_MODE, 32'h0);
    rd(8'h20, 1'b0, rdat, resp);
    chk({30'h0, resp}, {30'h0, ISF_RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk({30'h0, resp}, {30'h0, ISF_RESP_SLVERR});
    wr(ISF_ADDR_MODE, 32'h8);
    chk({30'h0, resp}, {30'h0, ISF_RESP_OKAY});
    @(posedge clk_i) settings_done_i <= 1'b1;
    @(posedge clk_i) settings_done_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h0);
    wr(ISF_ADDR_MODE, 32'hc);
    @(posedge clk_i) settings_done_i <= 1'b1;
    @(posedge clk_i) settings_done_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h4);
    @(posedge clk_i) settings_used_i <= 1'b1;
    @(posedge clk_i) settings_used_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h0);
    // hardware set held across the clearing write
    @(posedge clk_i) settings_done_i <= 1'b1;
    wr(ISF_ADDR_STATUS, 32'h4);
    settings_done_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h4);
    wr(ISF_ADDR_STATUS, 32'h4);
    rc(ISF_ADDR_STATUS, 32'h0);
    wr(ISF_ADDR_IRQ_EN, 32'hf);
    rx_byte_i <= 8'ha5;
    @(posedge clk_i) rx_byte_moved_i <= 1'b1;
    @(posedge clk_i) rx_byte_moved_i <= 1'b0;
    rc(ISF_ADDR_ISRC, {29'h0, ISF_CODE_RECEIVE_READY_FLAG});
    rc(ISF_ADDR_STATUS, 32'h8);
    rc(ISF_ADDR_RXDATA, 32'ha5);
    rc(ISF_ADDR_STATUS, 32'h0);
    cnt_load_i <= 8'h2;
    @(posedge clk_i) cnt_load_en_i <= 1'b1;
    @(posedge clk_i) cnt_load_en_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rc(ISF_ADDR_STATUS, 32'h0);
      @(posedge clk_i) cnt_dec_i <= 1'b1;
      @(posedge clk_i) cnt_dec_i <= 1'b0;
    end
    rc(ISF_ADDR_STATUS, 32'h4);
    wr(ISF_ADDR_STATUS, 32'h4);
    wr(ISF_ADDR_MODE, 32'he);
    cnt_load_i <= 8'h1;
    @(posedge clk_i) cnt_load_en_i <= 1'b1;
    @(posedge clk_i) cnt_load_en_i <= 1'b0;
    @(posedge clk_i) cnt_dec_i <= 1'b1;
    @(posedge clk_i) cnt_dec_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h0);
    chk({31'h0, saw_stop}, 32'h1);
    // repeat mode: count reaching zero leaves ready alone
    wr(ISF_ADDR_MODE, 32'hd);
    @(posedge clk_i) cnt_load_en_i <= 1'b1;
    @(posedge clk_i) cnt_load_en_i <= 1'b0;
    @(posedge clk_i) cnt_dec_i <= 1'b1;
    @(posedge clk_i) cnt_dec_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h0);
    wr(ISF_ADDR_MODE, 32'hc);
    transmitting_i <= 1'b1;
    ack_sample_i <= 1'b1;
    u_bus.start_c();
    u_bus.bit_c(1'b1);
    rc(ISF_ADDR_STATUS, 32'h1002);
    rc(ISF_ADDR_ISRC, {29'h0, ISF_CODE_NACK});
    rc(ISF_ADDR_STATUS, 32'h1000);
    u_bus.bit_c(1'b1);
    rd(ISF_ADDR_ISRC, 1'b1, rdat, resp);
    rc(ISF_ADDR_STATUS, 32'h1002);
    u_bus.bit_c(1'b0);
    rc(ISF_ADDR_STATUS, 32'h1000);
    u_bus.bit_c(1'b1);
    wr(ISF_ADDR_STATUS, 32'h2);
    rc(ISF_ADDR_STATUS, 32'h1000);
    general_call_i <= 1'b1;
    rc(ISF_ADDR_STATUS, 32'h1002);
    general_call_i <= 1'b0;
    transmitting_i <= 1'b0;
    ack_sample_i <= 1'b0;
    wr(ISF_ADDR_IRQ_EN, 32'h1);
    wr(ISF_ADDR_MODE, 32'he);
    wr(ISF_ADDR_CMD, 32'h1);
    rc(ISF_ADDR_STATUS, 32'h1001);
    chk({29'h0, stop_req_o, master_o, irq_o}, 32'h1);
    rd(ISF_ADDR_ISRC, 1'b1, rdat, resp);
    rc(ISF_ADDR_STATUS, 32'h1001);
    rc(ISF_ADDR_ISRC, {29'h0, ISF_CODE_AL});
    rc(ISF_ADDR_STATUS, 32'h1000);
    chk({31'h0, irq_o}, 32'h0);
    wr(ISF_ADDR_MODE, 32'he);
    // arbitration is only lost while sending as master
    transmitting_i <= 1'b1;
    @(posedge clk_i) arb_lost_i <= 1'b1;
    @(posedge clk_i) arb_lost_i <= 1'b0;
    transmitting_i <= 1'b0;
    rc(ISF_ADDR_STATUS, 32'h1001);
    chk({29'h0, stop_req_o, master_o, irq_o}, 32'h1);
    wr(ISF_ADDR_IRQ_EN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(ISF_ADDR_STATUS, 32'h1);
    rc(ISF_ADDR_STATUS, 32'h1000);
    wr(ISF_ADDR_MODE, 32'h0);
    u_bus.stop_c();
    wr(ISF_ADDR_MODE, 32'h8);
    rc(ISF_ADDR_STATUS, 32'h1000);
    u_bus.start_c();
    u_bus.stop_c();
    rc(ISF_ADDR_STATUS, 32'h0);
    end_of_test();
  end
endmodule // i2c_status_flag_logic_test
bind isf_flags isf_assertions u_chk (.clk_i, .rst_n_i, .s_awvalid_i, .s_awready_o, .s_wvalid_i,
  .s_wready_o, .s_bvalid_o, .s_bready_i, .s_bresp_o, .s_arvalid_i, .s_arready_o, .s_rvalid_o,
  .s_rready_i, .s_rdata_o, .rx_byte_moved_i, .settings_done_i, .arb_lost_i, .transmitting_i,
  .stop_gen_o,
  .master_o, .stop_req_o, .int_code_o);

// [verification/isf_assertions.sv]
// checker: port assertions of the status-flag block
`timescale 1ns/1ns
module isf_assertions
  import isf_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_awvalid_i,
  input wire logic        s_awready_o,
  input wire logic        s_wvalid_i,
  input wire logic        s_wready_o,
  input wire logic        s_bvalid_o,
  input wire logic        s_bready_i,
  input wire logic [1:0]  s_bresp_o,
  input wire logic        s_arvalid_i,
  input wire logic        s_arready_o,
  input wire logic        s_rvalid_o,
  input wire logic        s_rready_i,
  input wire logic [31:0] s_rdata_o,
  input wire logic        rx_byte_moved_i,
  input wire logic        settings_done_i,
  input wire logic        arb_lost_i,
  input wire logic        transmitting_i,
  input wire logic        stop_gen_o,
  input wire logic        master_o,
  input wire logic        stop_req_o,
  input wire logic [2:0]  int_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_arb_drops_master: assert property (arb_lost_i && master_o && transmitting_i
    |=> !(master_o || stop_req_o))
    else $error("master bits kept after arbitration loss");
  a_arb_sets_code: assert property (arb_lost_i && master_o && transmitting_i
    |=> int_code_o == ISF_CODE_AL)
    else $error("arbitration loss not reported");
  a_rx_sets_code: assert property (rx_byte_moved_i && int_code_o == ISF_CODE_NONE
    && !arb_lost_i && !settings_done_i |=> int_code_o == ISF_CODE_RECEIVE_READY_FLAG)
    else $error("receive ready not reported");
  a_stop_needs_req: assert property (stop_gen_o |-> stop_req_o)
    else $error("stop issued without stop request");
  a_read_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read answer late");
  a_read_holds: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data dropped");
  a_arready_low: assert property (s_rvalid_o |-> !s_arready_o)
    else $error("read taken while answer pending");
  a_write_answer: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
    |-> ##[1:2] s_bvalid_o)
    else $error("write answer late");
  a_bresp_holds: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped");
endmodule // isf_assertions

// [verification/isf_bus_model.sv]
// partner: another bus party making start, stop and bit cycles
`timescale 1ns/1ns
module isf_bus_model (
  output logic scl_o,
  output logic sda_o
);
  // lines are pulled up, so released means 1; clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // the 5 ns offset keeps line changes away from the block's clock edges
  task start_c;
    #5 sda_o = 1'b0;
    #80 scl_o = 1'b0;
    #80;
  endtask
  task bit_c(input logic b);
    #5 sda_o = b;
    #80 scl_o = 1'b1;
    #80 scl_o = 1'b0;
    #40 sda_o = 1'b1;
    #40;
  endtask
  task stop_c;
    #5 sda_o = 1'b0;
    #80 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #80;
  endtask
endmodule // isf_bus_model
